//--- design/rpr_bank.sv
// Registered output bank with power-up clear and test preload.
// Assumes pin levels arrive pre-sensed as super and high comparator bits.
`timescale 1ns/1ps
`default_nettype none
`include "rpr_cfg.svh"
module rpr_bank
  import rpr_pkg::*;
#(
  parameter int          N     = `RPR_NUM_REGS,
  parameter logic        GRADE = `RPR_GRADE_FAST
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             dev_clk,
  input  wire logic             oe_n,
  input  wire rpr_level_s       ctrl_pin,
  input  wire rpr_level_s [N-1:0] pin_in,
  input  wire logic [N-1:0]     next_state,
  output logic      [N-1:0]     pin_out,
  output logic      [N-1:0]     pin_oe,
  output logic      [N-1:0]     flop_q,
  output logic                  ready
);
  localparam int PW = 2 * N + 4;
  localparam int CW = $clog2(`RPR_PWRUP_CYCLES + 1);
  localparam logic [CW-1:0] CLR_LAST = CW'(`RPR_PWRUP_CYCLES - 1);
  localparam int PCW = CW + 1; // Spare bit so the check counter saturates past the clear
  localparam logic [PCW-1:0] PWR_MAX = '1;

  logic [PW-1:0]    raw;
  logic [PW-1:0]    syn;
  rpr_level_s [N-1:0] pin_s;
  rpr_level_s       ctrl_s;
  logic             oe_n_s;
  logic             dclk_s;
  logic             dclk_d;
  logic             ctrl_d;
  rpr_state_e       state;
  logic [CW-1:0]    clr_cnt;
  logic [N-1:0]     pin_high;
  logic [N-1:0]     pin_super;
  logic             cap_edge;
  logic [PCW-1:0]   pwr_cnt;

  // Every pin is foreign to clk, so all of them pass two flops
  assign raw = {pin_in, ctrl_pin, oe_n, dev_clk};
  rpr_sync #(.W(PW)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    (raw),
    .q    (syn)
  );
  assign dclk_s = syn[0];
  assign oe_n_s = syn[1];
  assign ctrl_s = syn[3:2];
  assign pin_s  = syn[PW-1:4];

  // Per-pin comparator bits, split out for the checks
  always_comb begin
    for (int k = 0; k < N; k++) begin
      pin_high[k]  = pin_s[k].preload_high_level;
      pin_super[k] = pin_s[k].super_level_voltage;
    end
  end

  // Falling back of a super pulse with outputs off; only the second grade captures on it
  assign cap_edge = (GRADE == `RPR_GRADE_SECOND) && oe_n_s && ctrl_d && !ctrl_s.super_level_voltage;

  // Decode of a forced pin into the value it preloads
  function automatic logic preload_bit(input rpr_level_s lv);
    if (GRADE == `RPR_GRADE_FAST)
      preload_bit = ~lv.super_level_voltage;
    else
      preload_bit = lv.preload_high_level;
  endfunction

  // Edge history of device clock and control pin
  always_ff @(posedge clk) begin
    if (srst) begin
      dclk_d <= 1'h0;
      ctrl_d <= 1'h0;
    end else begin
      dclk_d <= dclk_s;
      ctrl_d <= ctrl_s.super_level_voltage;
    end
  end

  // Mode sequencing; srst stands in for power being applied
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= RPR_RESET;
      clr_cnt <= '0;
    end else begin
      unique case (state)
        RPR_RESET: begin
          // Clear lasts the power-up time, synchronous like the real one
          if (clr_cnt == CLR_LAST) state <= RPR_RUN;
          clr_cnt <= clr_cnt + CW'(1);
        end
        RPR_RUN: begin
          // Fast grade enters only with outputs already disabled
          if (GRADE == `RPR_GRADE_FAST && oe_n_s && ctrl_s.super_level_voltage)
            state <= RPR_PRELOAD;
        end
        RPR_PRELOAD: begin
          if (!ctrl_s.super_level_voltage) state <= RPR_RUN;
        end
      endcase
    end
  end

  // Cycles since power came up, saturating; only the clear-length check reads it
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_cnt <= '0;
    end else if (pwr_cnt != PWR_MAX) begin
      pwr_cnt <= pwr_cnt + PCW'(1);
    end
  end

  // Flip-flop bank, one per registered output
  for (genvar i = 0; i < N; i++) begin : g_flop
    always_ff @(posedge clk) begin
      if (srst || state == RPR_RESET) begin
        flop_q[i] <= 1'h0;
      end else if (state == RPR_PRELOAD) begin
        flop_q[i] <= preload_bit(pin_s[i]);
      end else if (cap_edge) begin
        // Captured at the falling back of the super pulse
        flop_q[i] <= preload_bit(pin_s[i]);
      end else if (dclk_s && !dclk_d) begin
        flop_q[i] <= next_state[i];
      end
    end
  end

  // Inverting output stage; disabled by oe_n, during reset, and in preload
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out <= '1;
      pin_oe  <= '0;
    end else begin
      pin_out <= ~flop_q;
      pin_oe  <= {N{!oe_n_s && state == RPR_RUN}};
    end
  end

  assign ready = (state != RPR_RESET);

  // Checks
  a_clear_after_reset: assert property (@(posedge clk) disable iff (srst)
    $rose(ready) |-> flop_q == '0) else $error("flops not cleared at end of reset");
  a_output_inverts: assert property (@(posedge clk) disable iff (srst)
    ##1 pin_out == ~$past(flop_q)) else $error("output stage not inverting");
  a_edge_loads: assert property (@(posedge clk) disable iff (srst)
    (state == RPR_RUN && dclk_s && !dclk_d && !(oe_n_s && ctrl_d)) |=> flop_q == $past(next_state))
    else $error("rising edge did not load next state");
  a_no_edge_hold: assert property (@(posedge clk) disable iff (srst)
    (state == RPR_RUN && !(dclk_s && !dclk_d) && !ctrl_d) |=> $stable(flop_q))
    else $error("flops changed without clock edge");
  a_preload_entry: assert property (@(posedge clk) disable iff (srst)
    (state == RPR_PRELOAD) |-> $past(oe_n_s)) else $error("preload entered with outputs enabled");
  a_preload_disabled: assert property (@(posedge clk) disable iff (srst)
    (state == RPR_PRELOAD) |=> pin_oe == '0) else $error("pins driven during preload");
  a_reset_length: assert property (@(posedge clk)
    $fell(srst) |-> !ready [*8]) else $error("power-up clear too short");
  a_output_inverted_load: assert property (@(posedge clk) disable iff (srst)
    (flop_q[0] && state == RPR_RUN) |-> ##2 (!pin_out[0] || !$past(flop_q[0])))
    else $error("high flop not shown low");

  // Power-up clear: length, hold-off and the pin image it leaves
  a_clear_length: assert property (@(posedge clk) disable iff (srst)
    $rose(ready) |-> pwr_cnt == PCW'(`RPR_PWRUP_CYCLES))
    else $error("power-up clear length wrong");
  a_ready_stays: assert property (@(posedge clk) disable iff (srst)
    ready |=> ready)
    else $error("ready dropped without reset");
  a_clear_holds: assert property (@(posedge clk) disable iff (srst)
    !ready |=> flop_q == '0)
    else $error("flops loaded during power-up clear");
  a_pins_high_clear: assert property (@(posedge clk) disable iff (srst)
    !ready |=> pin_out == '1)
    else $error("pins not high during power-up clear");

  // Preload entry, contents and exit
  a_entry_disabled: assert property (@(posedge clk) disable iff (srst)
    (state == RPR_RUN && !oe_n_s) |=> state != RPR_PRELOAD)
    else $error("preload mode taken while outputs enabled");
  a_oe_off: assert property (@(posedge clk) disable iff (srst)
    oe_n_s |=> pin_oe == '0)
    else $error("pins driven while output enable is high");
  a_fast_contents: assert property (@(posedge clk) disable iff (srst)
    (GRADE == `RPR_GRADE_FAST && state == RPR_PRELOAD) |=> flop_q == ~$past(pin_super))
    else $error("fast preload loaded wrong level");
  a_exit_preload: assert property (@(posedge clk) disable iff (srst)
    (state == RPR_PRELOAD && !ctrl_s.super_level_voltage) |=> state == RPR_RUN)
    else $error("preload not left when control pin dropped");
  a_second_capture: assert property (@(posedge clk) disable iff (srst)
    (cap_edge && ready) |=> flop_q == $past(pin_high))
    else $error("second-grade capture loaded wrong level");

  // Main scenarios
  c_reset_done:   cover property (@(posedge clk) $rose(ready));
  c_preload:      cover property (@(posedge clk) state == RPR_PRELOAD ##1 state == RPR_RUN);
  c_clock_load:   cover property (@(posedge clk) state == RPR_RUN && dclk_s && !dclk_d);
  c_second_cap:   cover property (@(posedge clk) cap_edge && ready);
  c_outputs_on:   cover property (@(posedge clk) $rose(pin_oe[0]));
endmodule
`default_nettype wire

//--- design/rpr_cfg.svh
// Constants for the registered output bank: widths, grade encodings, timing.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef RPR_CFG_SVH
`define RPR_CFG_SVH
`define RPR_NUM_REGS        8
`define RPR_CLK_PERIOD_NS   50
`define RPR_PWRUP_CLEAR_NS  1000
`define RPR_PWRUP_CYCLES    (`RPR_PWRUP_CLEAR_NS / `RPR_CLK_PERIOD_NS)
`define RPR_SYNC_STAGES     2
`define RPR_GRADE_FAST      1'h0
`define RPR_GRADE_SECOND    1'h1
`endif

//--- design/rpr_pkg.sv
// Types for the registered output bank.
// Assumes rpr_cfg.svh is on the include path.
`include "rpr_cfg.svh"
package rpr_pkg;
  // Three-level pin sense as seen after comparators
  typedef struct packed {
    logic super_level_voltage;
    logic preload_high_level;
  } rpr_level_s;
  typedef enum logic [1:0] {
    RPR_RESET,
    RPR_RUN,
    RPR_PRELOAD
  } rpr_state_e;
endpackage

//--- design/rpr_sync.sv
// Two-stage synchroniser for a bus of pin levels.
// Assumes the inputs come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module rpr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

//--- bench/rpr_tester.sv
// Tester model: drives the control pins of the bank.
// Assumes tasks are called at a clk rising edge.
`timescale 1ns/1ps
`default_nettype none
module rpr_tester
  import rpr_pkg::*;
(
  input  wire logic        clk,
  output logic             dev_clk,
  output logic             oe_n,
  output var rpr_level_s       ctrl_pin,
  output var rpr_level_s [7:0] pin_in
);
  // Quiet pins at power-up, device clock held low
  initial begin
    dev_clk = 1'h0;
    oe_n = 1'h0;
    ctrl_pin = '0;
    pin_in = '0;
  end
  // Spacing covers the two-flop pin sync
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One rising edge on the device clock
  task automatic pulse_clk();
    dev_clk <= 1'h1;
    step(4);
    dev_clk <= 1'h0;
    step(4);
  endtask
  // Preload; ctrl fall also captures for the second grade
  task automatic preload(input logic [7:0] p);
    oe_n <= 1'h1;
    step(5);
    ctrl_pin <= 2'h3;
    step(5);
    for (int i = 0; i < 8; i++) pin_in[i] <= p[i] ? 2'h3 : 2'h0;
    step(5);
    ctrl_pin <= 2'h0;
    step(5);
    pin_in <= ~pin_in;
    step(5);
    oe_n <= 1'h0;
    step(5);
  endtask
endmodule
`default_nettype wire

//--- bench/rpr_bank_tb.sv
// Bench for the bank: reset, clocked load, preload.
// Assumes rpr_tester drives the pin side.
`timescale 1ns/1ps
`default_nettype none
`include "rpr_cfg.svh"
module rpr_bank_tb;
  import rpr_pkg::*;
  logic             clk;
  logic             srst;
  logic [7:0]       next_state;
  logic             dev_clk;
  logic             oe_n;
  rpr_level_s       ctrl_pin;
  rpr_level_s [7:0] pin_in;
  logic [7:0]       pin_out;
  logic [7:0]       pin_oe;
  logic [7:0]       flop_q;
  logic [7:0]       flop_q2;
  logic [7:0]       pin_out2;
  logic             ready;
  int               mismatches = 0;
  int               n_tests = 0;
  // Fast grade bank and a second-grade twin
  rpr_bank #(.GRADE(1'h0)) DUT (.clk(clk), .srst(srst), .dev_clk(dev_clk), .oe_n(oe_n), .ctrl_pin(ctrl_pin),
    .pin_in(pin_in), .next_state(next_state), .pin_out(pin_out), .pin_oe(pin_oe), .flop_q(flop_q), .ready(ready));
  rpr_bank #(.GRADE(1'h1)) DUT2 (.clk(clk), .srst(srst), .dev_clk(dev_clk), .oe_n(oe_n), .ctrl_pin(ctrl_pin),
    .pin_in(pin_in), .next_state(next_state), .pin_out(pin_out2), .pin_oe(), .flop_q(flop_q2), .ready());
  rpr_tester TST (.clk(clk), .dev_clk(dev_clk), .oe_n(oe_n), .ctrl_pin(ctrl_pin), .pin_in(pin_in));
  // 50 ns clock
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Clear state during reset, then count the clear time
  task automatic t_reset();
    int n;
    repeat (4) @(posedge clk);
    #1;
    chk(flop_q, 8'h00);
    chk(flop_q2, 8'h00);
    chk(pin_out, 8'hFF);
    @(posedge clk) srst <= 1'h0;
    n = 0;
    while (ready !== 1'h1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      results();
    end
    chk(8'(n), 8'(`RPR_PWRUP_CYCLES));
  endtask
  // Loads only on a device clock rise, shown inverted
  task automatic t_run();
    @(posedge clk) next_state <= 8'hA5;
    TST.step(6);
    #1;
    chk(flop_q, 8'h00);
    @(posedge clk);
    TST.pulse_clk();
    next_state <= 8'h3C;
    TST.step(6);
    #1;
    chk(flop_q, 8'hA5);
    chk(flop_q2, 8'hA5);
    chk(pin_out, 8'h5A);
    chk(pin_oe, 8'hFF);
  endtask
  // Preload both grades from one pattern
  task automatic t_preload(input logic [7:0] p);
    @(posedge clk);
    TST.preload(p);
    #1;
    chk(flop_q, ~p);
    chk(flop_q2, p);
    chk(pin_out, p);
    chk(pin_out2, ~p);
    chk(pin_oe, 8'hFF);
  endtask
  // Main sequence
  initial begin
    clk = 1'h0;
    srst = 1'h1;
    next_state = 8'h00;
    t_reset();
    t_run();
    t_preload(8'h96);
    @(posedge clk);
    t_preload(8'hFF);
    results();
  end
endmodule
`default_nettype wire
